// File: logic/dtcal_consts.svh
// Purpose: named constants for the excitation DAC trim register bank
// Assumes: AHB-Lite word access, byte addresses as printed
// Notes:   included by the package and the bank module
`ifndef DTCAL_CONSTS_SVH
`define DTCAL_CONSTS_SVH

`define DTCAL_ADDR_W          14
`define DTCAL_OFS_UNLOCK_KEY  14'h2230
`define DTCAL_OFS_GAIN        14'h2260
`define DTCAL_OFS_OFF_ATT_LP  14'h2264
`define DTCAL_OFS_OFF_NAT_LP  14'h2268
`define DTCAL_OFS_OFF_ATT_HS  14'h22b8
`define DTCAL_OFS_OFF_NAT_HS  14'h22bc
`define DTCAL_OFS_DAC_CONFIG  14'h2010
`define DTCAL_OFS_MODE        14'h2300
`define DTCAL_OFS_ACTIVE      14'h2304

`define DTCAL_KEY_VALUE       32'hde87a5af
`define DTCAL_KEY_RESET       32'hde87a5a0
`define DTCAL_GAIN_RESET      12'h800
`define DTCAL_OFF_RESET       12'h000
`define DTCAL_CFG_RESET       13'h001e
`define DTCAL_TRIM_W          12
`define DTCAL_CFG_W           13
`define DTCAL_BIT_GAIN_SEL    12
`define DTCAL_BIT_ATTEN_EN    0
`define DTCAL_BIT_MODE_HS     0
`define DTCAL_OUT_LAT         2
`define DTCAL_CFG_RATE_HI     11
`define DTCAL_CFG_RATE_LO     1
`define DTCAL_HTRANS_NONSEQ   2'h2
`define DTCAL_HSIZE_WORD      3'h2

`endif

// File: logic/dtcal_pkg.sv
// Purpose: types for the excitation DAC trim register bank
// Assumes: constants header provides the address, trim and config widths
// Notes:   one packed struct carries the whole state of the bank
`include "dtcal_consts.svh"

package dtcal_pkg;

    typedef struct packed {
        logic [`DTCAL_ADDR_W-1:0] addr;
        logic                     write;
        logic                     valid;
    } dtcal_aphase_type;

    typedef struct packed {
        logic [31:0]              unlock_key;
        logic [`DTCAL_TRIM_W-1:0] gain;
        logic [`DTCAL_TRIM_W-1:0] off_att_lp;
        logic [`DTCAL_TRIM_W-1:0] off_nat_lp;
        logic [`DTCAL_TRIM_W-1:0] off_att_hs;
        logic [`DTCAL_TRIM_W-1:0] off_nat_hs;
        logic [`DTCAL_CFG_W-1:0]  dac_config;
        logic                     high_speed;
        logic [`DTCAL_TRIM_W-1:0] active_offset;
        logic [`DTCAL_TRIM_W-1:0] active_gain;
        logic                     gain_select;
        logic                     atten_enable;
        logic [31:0]              rdata;
        dtcal_aphase_type         aphase;
    } dtcal_state_type;

endpackage

// File: logic/dtcal_regs.sv
// Purpose: trim register bank for the excitation DAC, AHB-Lite slave
// Assumes: single word transfers, one clock, async active-high reset
// Notes:   zero wait states; trims reach the DAC one cycle after a write
`timescale 1ns/1ps
`default_nettype none
`include "dtcal_consts.svh"

module dtcal_regs
    import dtcal_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic      [11:0] o_gain_trim,
    output logic      [11:0] o_offset_trim,
    output logic             o_amp_gain_select,
    output logic             o_output_atten_enable
);

    dtcal_state_type st_r;
    dtcal_state_type st_nxt;
    logic            unlocked;
    logic            take;
    logic            wr;
    logic            rd_next;
    logic [31:0]     rd_val;
    logic [11:0]     sel_off;
    logic [`DTCAL_ADDR_W-1:0] aaddr;

    // all checks below run on the one system clock
    default clocking dtcal_cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // ==========================================================
    // bus decode
    // ==========================================================
    assign take = i_hsel && i_hready && (i_htrans == `DTCAL_HTRANS_NONSEQ)
                  && (i_hsize == `DTCAL_HSIZE_WORD);
    assign wr   = st_r.aphase.valid && st_r.aphase.write;
    assign aaddr = i_haddr[`DTCAL_ADDR_W-1:0];
    assign rd_next = take && !i_hwrite;

    // any other value keeps trims locked
    assign unlocked = (st_r.unlock_key == `DTCAL_KEY_VALUE);

    // ==========================================================
    // offset selection
    // ==========================================================
    // atten enabled picks atten word
    always_comb
    begin
        if (st_r.high_speed)
            sel_off = st_r.dac_config[`DTCAL_BIT_ATTEN_EN] ?
                      st_r.off_att_hs : st_r.off_nat_hs;
        else
            sel_off = st_r.dac_config[`DTCAL_BIT_ATTEN_EN] ?
                      st_r.off_att_lp : st_r.off_nat_lp;
    end

    // ==========================================================
    // read mux
    // ==========================================================
    // upper bits of trims read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (aaddr)
            `DTCAL_OFS_UNLOCK_KEY: rd_val = st_r.unlock_key;
            `DTCAL_OFS_GAIN:       rd_val = {20'h00000, st_r.gain};
            `DTCAL_OFS_OFF_ATT_LP: rd_val = {20'h00000, st_r.off_att_lp};
            `DTCAL_OFS_OFF_NAT_LP: rd_val = {20'h00000, st_r.off_nat_lp};
            `DTCAL_OFS_OFF_ATT_HS: rd_val = {20'h00000, st_r.off_att_hs};
            `DTCAL_OFS_OFF_NAT_HS: rd_val = {20'h00000, st_r.off_nat_hs};
            `DTCAL_OFS_DAC_CONFIG: rd_val = {19'h00000, st_r.dac_config};
            `DTCAL_OFS_MODE:       rd_val = {31'h00000000, st_r.high_speed};
            `DTCAL_OFS_ACTIVE:     rd_val = {8'h00, st_r.active_gain,
                                             st_r.active_offset};
            default:               rd_val = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.aphase.valid = take;
        st_nxt.aphase.write = i_hwrite;
        st_nxt.aphase.addr  = aaddr;
        if (rd_next)
            st_nxt.rdata = rd_val;
        else
            st_nxt.rdata = 32'h0000_0000;
        if (wr)
        begin
            unique case (st_r.aphase.addr)
                `DTCAL_OFS_UNLOCK_KEY:
                    st_nxt.unlock_key = i_hwdata;
                `DTCAL_OFS_GAIN:
                    if (unlocked)
                        st_nxt.gain = i_hwdata[`DTCAL_TRIM_W-1:0];
                `DTCAL_OFS_OFF_ATT_LP:
                    if (unlocked)
                        st_nxt.off_att_lp = i_hwdata[`DTCAL_TRIM_W-1:0];
                `DTCAL_OFS_OFF_NAT_LP:
                    if (unlocked)
                        st_nxt.off_nat_lp = i_hwdata[`DTCAL_TRIM_W-1:0];
                `DTCAL_OFS_OFF_ATT_HS:
                    if (unlocked)
                        st_nxt.off_att_hs = i_hwdata[`DTCAL_TRIM_W-1:0];
                `DTCAL_OFS_OFF_NAT_HS:
                    if (unlocked)
                        st_nxt.off_nat_hs = i_hwdata[`DTCAL_TRIM_W-1:0];
                // config is not calibration data, never locked
                `DTCAL_OFS_DAC_CONFIG:
                    st_nxt.dac_config = i_hwdata[`DTCAL_CFG_W-1:0];
                `DTCAL_OFS_MODE:
                    st_nxt.high_speed = i_hwdata[`DTCAL_BIT_MODE_HS];
                default:
                    st_nxt.high_speed = st_r.high_speed;
            endcase
        end
        // single gain word for every combination
        st_nxt.active_gain   = st_r.gain;
        // offset passed as signed code unchanged
        st_nxt.active_offset = sel_off;
        st_nxt.gain_select   = st_r.dac_config[`DTCAL_BIT_GAIN_SEL];
        st_nxt.atten_enable  = st_r.dac_config[`DTCAL_BIT_ATTEN_EN];
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_r.unlock_key    <= `DTCAL_KEY_RESET;
            st_r.gain          <= `DTCAL_GAIN_RESET;
            st_r.off_att_lp    <= `DTCAL_OFF_RESET;
            st_r.off_nat_lp    <= `DTCAL_OFF_RESET;
            st_r.off_att_hs    <= `DTCAL_OFF_RESET;
            st_r.off_nat_hs    <= `DTCAL_OFF_RESET;
            st_r.dac_config    <= `DTCAL_CFG_RESET;
            st_r.high_speed    <= 1'b0;
            st_r.active_offset <= `DTCAL_OFF_RESET;
            st_r.active_gain   <= `DTCAL_GAIN_RESET;
            st_r.gain_select   <= 1'b0;
            st_r.atten_enable  <= 1'b0;
            st_r.rdata         <= 32'h0000_0000;
            st_r.aphase        <= '0;
        end
        else
            st_r <= st_nxt;
    end

    assign o_hrdata              = st_r.rdata;
    assign o_hreadyout           = 1'b1;
    assign o_hresp               = 1'b0;
    assign o_gain_trim           = st_r.active_gain;
    assign o_offset_trim         = st_r.active_offset;
    assign o_amp_gain_select     = st_r.gain_select;
    assign o_output_atten_enable = st_r.atten_enable;

    // ==========================================================
    // assertions
    // ==========================================================
    // named sequences keep the lock cases apart; the locked hs atten write is checked inline
    sequence s_key_write;
        wr && st_r.aphase.addr == `DTCAL_OFS_UNLOCK_KEY
        && i_hwdata == `DTCAL_KEY_VALUE;
    endsequence

    sequence s_wrong_key;
        wr && st_r.aphase.addr == `DTCAL_OFS_UNLOCK_KEY
        && i_hwdata != `DTCAL_KEY_VALUE;
    endsequence

    sequence s_locked_trim_write;
        wr && !unlocked && st_r.aphase.addr == `DTCAL_OFS_GAIN;
    endsequence

    sequence s_open_gain;
        wr && unlocked && st_r.aphase.addr == `DTCAL_OFS_GAIN;
    endsequence

    sequence s_locked_att_lp;
        wr && !unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_ATT_LP;
    endsequence

    sequence s_locked_nat_lp;
        wr && !unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_NAT_LP;
    endsequence

    sequence s_locked_nat_hs;
        wr && !unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_NAT_HS;
    endsequence

    sequence s_open_att_lp;
        wr && unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_ATT_LP;
    endsequence

    sequence s_open_att_hs;
        wr && unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_ATT_HS;
    endsequence

    sequence s_key_read;
        rd_next && aaddr == `DTCAL_OFS_UNLOCK_KEY;
    endsequence

    // key compare is exact: one bit off must leave the bank locked
    a_key_unlocks: assert property (
        s_key_write |=> unlocked)
        else $error("key write did not unlock");

    a_wrong_key: assert property (
        s_wrong_key |=> !unlocked)
        else $error("wrong key unlocked the bank");

    a_lock_holds_gain: assert property (
        s_locked_trim_write |=> $stable(st_r.gain))
        else $error("locked gain changed");

    a_lp_att_locked: assert property (
        s_locked_att_lp |=> $stable(st_r.off_att_lp))
        else $error("locked lp atten offset changed");

    a_lp_nat_locked: assert property (
        s_locked_nat_lp |=> $stable(st_r.off_nat_lp))
        else $error("locked lp plain offset changed");

    a_hs_nat_locked: assert property (
        s_locked_nat_hs |=> $stable(st_r.off_nat_hs))
        else $error("locked hs plain offset changed");

    // register lands after the data phase, output one edge later
    a_gain_written: assert property (
        s_open_gain |=> ##1 o_gain_trim ==
            $past(i_hwdata[`DTCAL_TRIM_W-1:0], `DTCAL_OUT_LAT))
        else $error("unlocked gain write not applied");

    a_gain_all_modes: assert property (
        1'b1 |=> o_gain_trim == $past(st_r.gain))
        else $error("gain word not applied");

    // first edge after release must still show the reset values
    a_reset_gain: assert property (
        $past(i_reset) |-> o_gain_trim == `DTCAL_GAIN_RESET)
        else $error("gain not midscale after reset");

    a_off_stored: assert property (
        s_open_att_lp |=> st_r.off_att_lp == $past(i_hwdata[`DTCAL_TRIM_W-1:0]))
        else $error("offset code not stored as written");

    a_reset_offset: assert property (
        $past(i_reset) |-> o_offset_trim == `DTCAL_OFF_RESET)
        else $error("offset not zero after reset");

    // output offset follows the word chosen on the previous edge
    a_offset_atten: assert property (
        st_r.dac_config[`DTCAL_BIT_ATTEN_EN] && st_r.high_speed
        |=> o_offset_trim == $past(st_r.off_att_hs))
        else $error("wrong hs atten offset selected");

    a_lp_pair: assert property (
        st_r.dac_config[`DTCAL_BIT_ATTEN_EN] && !st_r.high_speed
        |=> o_offset_trim == $past(st_r.off_att_lp))
        else $error("wrong lp atten offset selected");

    a_offset_noatten: assert property (
        !st_r.dac_config[`DTCAL_BIT_ATTEN_EN] && !st_r.high_speed
        |=> o_offset_trim == $past(st_r.off_nat_lp))
        else $error("wrong lp plain offset selected");

    a_hs_plain: assert property (
        !st_r.dac_config[`DTCAL_BIT_ATTEN_EN] && st_r.high_speed
        |=> o_offset_trim == $past(st_r.off_nat_hs))
        else $error("wrong hs plain offset selected");

    a_hs_att_locked: assert property (
        wr && !unlocked && st_r.aphase.addr == `DTCAL_OFS_OFF_ATT_HS
        |=> $stable(st_r.off_att_hs))
        else $error("locked hs atten offset changed");

    a_hs_att_written: assert property (
        s_open_att_hs |=> st_r.off_att_hs == $past(i_hwdata[`DTCAL_TRIM_W-1:0]))
        else $error("unlocked hs atten write not applied");

    a_gain_select_out: assert property (
        1'b1 |=> o_amp_gain_select == $past(st_r.dac_config[`DTCAL_BIT_GAIN_SEL]))
        else $error("gain select not forwarded");

    a_atten_out: assert property (
        1'b1 |=> o_output_atten_enable == $past(st_r.dac_config[`DTCAL_BIT_ATTEN_EN]))
        else $error("atten enable not forwarded");

    // read data only stands in the data phase, zero otherwise
    a_upper_zero: assert property (
        (rd_next && aaddr == `DTCAL_OFS_GAIN) |=> o_hrdata[31:12] == 20'h00000)
        else $error("trim upper bits not zero");

    a_key_readback: assert property (
        s_key_read |=> o_hrdata == $past(st_r.unlock_key))
        else $error("key did not read back");

    a_rdata_idle: assert property (
        !rd_next |=> o_hrdata == 32'h0000_0000)
        else $error("read data outside data phase");

endmodule
`default_nettype wire

// File: test/test_dac_trim_calibration_regs.sv
// Purpose: self-checking bench for the excitation DAC trim register bank
// Assumes: zero wait-state slave, single word transfers
// Notes:   a near-miss key is tried first, since a loose compare would pass it
`timescale 1ns/1ps
`default_nettype none
`include "dtcal_consts.svh"

module test_dac_trim_calibration_regs
    import dtcal_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [11:0] gain_trim;
    logic [11:0] offset_trim;
    logic        gain_sel;
    logic        atten_en;
    logic [31:0] rd;
    logic        hs;
    logic        g;
    logic        a;
    logic [11:0] exp_off;
    int          miscompares = 0;
    int          compares = 0;
    logic [13:0] ofs_addr [4] = '{`DTCAL_OFS_OFF_ATT_LP, `DTCAL_OFS_OFF_NAT_LP,
                                  `DTCAL_OFS_OFF_ATT_HS, `DTCAL_OFS_OFF_NAT_HS};
    logic [11:0] ofs_val  [4] = '{12'h7ff, 12'h001, 12'h800, 12'hfff};

    always #20 clk = ~clk;

    dtcal_regs uut (
        .i_clk                 (clk),
        .i_reset               (reset),
        .i_hsel                (hsel),
        .i_haddr               (haddr),
        .i_htrans              (htrans),
        .i_hwrite              (hwrite),
        .i_hsize               (hsize),
        .i_hwdata              (hwdata),
        .i_hready              (hreadyout),
        .o_hrdata              (hrdata),
        .o_hreadyout           (hreadyout),
        .o_hresp               (hresp),
        .o_gain_trim           (gain_trim),
        .o_offset_trim         (offset_trim),
        .o_amp_gain_select     (gain_sel),
        .o_output_atten_enable (atten_en)
    );

    // ========================================
    // bus tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // hwdata is inverted after use so a stale bus value cannot look right
    task automatic bus(input logic wr, input logic [13:0] ad,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {18'h0, ad};
        htrans <= `DTCAL_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= `DTCAL_HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask

    task automatic reg_write(input logic [13:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, rd);
    endtask

    task automatic reg_check(input logic [13:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0, rd);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    // trims reach the outputs one cycle after the register update
    task automatic out_check(input logic [11:0] eg, input logic [11:0] eo,
                             input logic es, input logic ea);
        repeat (2) @(posedge clk);
        check({6'h0, gain_trim, offset_trim, gain_sel, atten_en},
              {6'h0, eg, eo, es, ea});
    endtask

    task automatic tally_and_finish;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ========================================
    // tests
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        reg_check(`DTCAL_OFS_UNLOCK_KEY, `DTCAL_KEY_RESET);
        reg_check(`DTCAL_OFS_GAIN, 32'h0000_0800);
        for (int i = 0; i < 4; i++)
            reg_check(ofs_addr[i], 32'h0);
        reg_check(`DTCAL_OFS_DAC_CONFIG, 32'h0000_001e);
        out_check(12'h800, 12'h000, 1'b0, 1'b0);
        $display("test reset_defaults done");
        reg_write(`DTCAL_OFS_UNLOCK_KEY, 32'hde87_a5ae);
        reg_check(`DTCAL_OFS_UNLOCK_KEY, 32'hde87_a5ae);
        reg_write(`DTCAL_OFS_GAIN, 32'h0000_0123);
        reg_write(`DTCAL_OFS_OFF_ATT_HS, 32'h0000_0456);
        reg_check(`DTCAL_OFS_GAIN, 32'h0000_0800);
        reg_check(`DTCAL_OFS_OFF_ATT_HS, 32'h0);
        $display("test locked_writes done");
        reg_write(`DTCAL_OFS_UNLOCK_KEY, `DTCAL_KEY_VALUE);
        reg_write(`DTCAL_OFS_GAIN, 32'hffff_ffff);
        reg_check(`DTCAL_OFS_GAIN, 32'h0000_0fff);
        for (int i = 0; i < 4; i++)
            reg_write(ofs_addr[i], {20'hfffff, ofs_val[i]});
        for (int i = 0; i < 4; i++)
            reg_check(ofs_addr[i], {20'h0, ofs_val[i]});
        $display("test unlocked_writes done");
        for (int m = 0; m < 8; m++)
        begin
            {hs, g, a} = 3'(m);
            exp_off = ofs_val[{hs, ~a}];
            reg_write(`DTCAL_OFS_DAC_CONFIG, {19'h0, g, 3'h0, 8'h0f, a});
            reg_write(`DTCAL_OFS_MODE, {31'h0, hs});
            out_check(12'hfff, exp_off, g, a);
            reg_check(`DTCAL_OFS_ACTIVE, {8'h0, 12'hfff, exp_off});
        end
        $display("test offset_selection done");
        reg_write(`DTCAL_OFS_UNLOCK_KEY, 32'h0);
        reg_write(`DTCAL_OFS_OFF_ATT_HS, 32'h0000_0123);
        reg_write(`DTCAL_OFS_GAIN, 32'h0);
        reg_check(`DTCAL_OFS_OFF_ATT_HS, 32'h0000_0800);
        reg_check(`DTCAL_OFS_GAIN, 32'h0000_0fff);
        reg_write(14'h2270, 32'hffff_ffff);
        reg_check(14'h2270, 32'h0);
        $display("test relock_unmapped done");
        tally_and_finish;
    end

    // roughly 190 cycles of traffic; the margin covers slow answers
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end
endmodule

`default_nettype wire
